// ### vic_pkg.sv
package vic_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int REQ_COUNT = 14;
    localparam int REQ_WIDTH = 16;
    localparam int RANK_BITS = 4;

    // ************************************************************
    // register map (byte addresses on the register port)
    // ************************************************************
    localparam logic [15:0] ADDR_REQUEST_ONE = 16'h00FC;
    localparam logic [15:0] ADDR_REQUEST_TWO = 16'h00FD;
    localparam logic [15:0] ADDR_ENABLE_ONE = 16'h00FE;
    localparam logic [15:0] ADDR_ENABLE_TWO = 16'h00FF;
    localparam logic [15:0] ADDR_POLARITY = 16'h0212;

    // ************************************************************
    // polarity register fields and reset values
    // ************************************************************
    localparam int POL_ONE_BIT = 3;
    localparam int POL_TWO_BIT = 4;
    localparam int POL_THREE_BIT = 6;
    localparam int SHARED_SEL_BIT = 7;
    localparam logic [7:0] POLARITY_RESET = 8'h00;
    localparam logic [7:0] REQUEST_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] LIVE_BITS = 8'h7F;

    // ************************************************************
    // request bit positions in {request_two, request_one}
    // ************************************************************
    localparam int POS_TIMER_ONE = 0;
    localparam int POS_TIMER_TWO = 1;
    localparam int POS_TIMER_THREE = 2;
    localparam int POS_TIMER_FOUR = 3;
    localparam int POS_OVERLAY = 4;
    localparam int POS_VSYNC = 5;
    localparam int POS_ADC_PIN_THREE = 6;
    localparam int POS_PIN_ONE = 8;
    localparam int POS_PIN_TWO = 9;
    localparam int POS_SLICER = 10;
    localparam int POS_SERIAL = 11;
    localparam int POS_PERIODIC_SPRITE = 12;
    localparam int POS_I2C = 13;
    localparam int POS_TIMER_FIVE_SIX = 14;

    // ************************************************************
    // vectors and status word layout
    // ************************************************************
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TOP_MASKABLE = 16'hFFFC;
    localparam logic [15:0] VEC_BREAK = 16'hFFDE;
    localparam int PS_I_BIT = 2;
    localparam int PS_B_BIT = 4;

    typedef struct packed {
        logic timer_one;
        logic timer_two;
        logic timer_three;
        logic timer_four;
        logic timer_five_six;
        logic screen_overlay_done_irq;
        logic data_slicer;
        logic serial_io;
        logic periodic_or_sprite;
        logic i2c_bus;
        logic adc_done;
    } periph_event_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } mem_req_t;

    typedef enum {
        ST_IDLE,
        ST_PUSH_HI,
        ST_PUSH_LO,
        ST_PUSH_PS,
        ST_VEC_LO,
        ST_VEC_HI,
        ST_LOAD
    } seq_state_t;

endpackage

// ### vectored_interrupt_control.sv
// Summary of operation
// - seventeen sources: three pins, vertical sync, eleven peripheral events, break trap and reset
// - on acceptance push program counter and status word before the vector fetch
// - on acceptance set disable flag and clear the accepted request bit
// - after stacking load program counter from the source's two-byte vector
// - no maskable acceptance while the disable flag is one
// - every source but break and reset has a request bit and an enable bit
// - maskable acceptance needs enable one, request one and disable flag zero
// - software may clear request bits, never set them; hardware sets them
// - enable bits are freely writable and read back
// - reset acts as a non-maskable source above all others
// - vertical sync request raised on a rising edge of the synchronised vertical sync input
// - overlay request raised when a character block display completes
// - pins one and two raise requests on edges chosen by polarity bits 3, 4
// - both pin polarity bits clear at reset, rising edge by default
// - timer one to four overflow sets the matching request bit
// - sixteen fixed priority levels, reset first, break trap last
// - each level has its own vector pair, descending from the reset pair
// - reset loads program counter from the reset vector and sets disable flag
// - polarity bit 7 selects pin three or conversion done for the shared vector
// - polarity bit 6 selects pin three's edge and clears at reset
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_control (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    input wire logic ext_irq_pin_one_i,
    input wire logic ext_irq_pin_two_i,
    input wire logic ext_irq_pin_three_i,
    input wire logic vsync_i,
    input wire vic_pkg::periph_event_t periph_evt_i,
    input wire logic break_software_trap_i,
    input wire logic boundary_i,
    input wire logic i_flag_clear_i,
    input wire logic i_flag_set_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] sp_i,
    input wire logic [7:0] stack_page_i,
    output vic_pkg::mem_req_t mem_o,
    input wire logic [7:0] mem_rdata_i,
    output logic busy_o,
    output logic i_flag_o,
    output logic pc_load_o,
    output logic [7:0] prog_counter_high_o,
    output logic [7:0] prog_counter_low_o,
    output logic [7:0] processor_status_word_o,
    output logic [7:0] sp_o
);

    // ************************************************************
    // ranking of maskable sources, level 2 first
    // ************************************************************
    localparam int RANK_POS [vic_pkg::REQ_COUNT] = '{
        vic_pkg::POS_OVERLAY, vic_pkg::POS_PIN_ONE, vic_pkg::POS_SLICER,
        vic_pkg::POS_SERIAL, vic_pkg::POS_TIMER_FOUR, vic_pkg::POS_PERIODIC_SPRITE,
        vic_pkg::POS_VSYNC, vic_pkg::POS_TIMER_THREE, vic_pkg::POS_TIMER_TWO,
        vic_pkg::POS_TIMER_ONE, vic_pkg::POS_ADC_PIN_THREE, vic_pkg::POS_PIN_TWO,
        vic_pkg::POS_I2C, vic_pkg::POS_TIMER_FIVE_SIX};

    // lowest rank with a ready request wins
    function automatic logic [vic_pkg::RANK_BITS-1:0] pick_rank(
        input logic [vic_pkg::REQ_WIDTH-1:0] ready
    );
        logic [vic_pkg::RANK_BITS-1:0] k;
        k = '0;
        for (int i = vic_pkg::REQ_COUNT - 1; i >= 0; i--)
        begin
            if (ready[RANK_POS[i]])
            begin
                k = i[vic_pkg::RANK_BITS-1:0];
            end
        end
        return k;
    endfunction

    function automatic logic [vic_pkg::REQ_WIDTH-1:0] rank_mask(
        input logic [vic_pkg::RANK_BITS-1:0] k
    );
        logic [vic_pkg::REQ_WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < vic_pkg::REQ_COUNT; i++)
        begin
            if (k == i[vic_pkg::RANK_BITS-1:0])
            begin
                m[RANK_POS[i]] = 1'b1;
            end
        end
        return m;
    endfunction

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [3:0] pin_prev_reg;
    logic [3:0] pin_raw;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    assign pin_raw = {vsync_i, ext_irq_pin_three_i, ext_irq_pin_two_i, ext_irq_pin_one_i};

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
            pin_prev_reg <= 4'h0;
        end
        else
        begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign pin_rise = pin_sync_reg & ~pin_prev_reg;
    assign pin_fall = ~pin_sync_reg & pin_prev_reg;

    // ************************************************************
    // polarity and shared source selection
    // ************************************************************
    logic pin_one_edge_select;
    logic pin_two_edge_select;
    logic pin_three_edge_select;
    logic shared_vector_source_select;
    logic [7:0] polarity_reg;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            polarity_reg <= vic_pkg::POLARITY_RESET;
        end
        else if (reg_we_i && reg_addr_i == vic_pkg::ADDR_POLARITY)
        begin
            polarity_reg <= reg_wdata_i;
        end
    end

    assign pin_one_edge_select = polarity_reg[vic_pkg::POL_ONE_BIT];
    assign pin_two_edge_select = polarity_reg[vic_pkg::POL_TWO_BIT];
    assign pin_three_edge_select = polarity_reg[vic_pkg::POL_THREE_BIT];
    assign shared_vector_source_select = polarity_reg[vic_pkg::SHARED_SEL_BIT];

    // ************************************************************
    // event collection
    // ************************************************************
    logic [vic_pkg::REQ_WIDTH-1:0] event_vec;

    always_comb
    begin
        event_vec = '0;
        event_vec[vic_pkg::POS_TIMER_ONE] = periph_evt_i.timer_one;
        event_vec[vic_pkg::POS_TIMER_TWO] = periph_evt_i.timer_two;
        event_vec[vic_pkg::POS_TIMER_THREE] = periph_evt_i.timer_three;
        event_vec[vic_pkg::POS_TIMER_FOUR] = periph_evt_i.timer_four;
        event_vec[vic_pkg::POS_OVERLAY] = periph_evt_i.screen_overlay_done_irq;
        event_vec[vic_pkg::POS_VSYNC] = pin_rise[3];
        // shared vector: pin three or conversion done
        event_vec[vic_pkg::POS_ADC_PIN_THREE] = shared_vector_source_select ?
            periph_evt_i.adc_done :
            (pin_three_edge_select ? pin_fall[2] : pin_rise[2]);
        event_vec[vic_pkg::POS_PIN_ONE] = pin_one_edge_select ? pin_fall[0] : pin_rise[0];
        event_vec[vic_pkg::POS_PIN_TWO] = pin_two_edge_select ? pin_fall[1] : pin_rise[1];
        event_vec[vic_pkg::POS_SLICER] = periph_evt_i.data_slicer;
        event_vec[vic_pkg::POS_SERIAL] = periph_evt_i.serial_io;
        event_vec[vic_pkg::POS_PERIODIC_SPRITE] = periph_evt_i.periodic_or_sprite;
        event_vec[vic_pkg::POS_I2C] = periph_evt_i.i2c_bus;
        event_vec[vic_pkg::POS_TIMER_FIVE_SIX] = periph_evt_i.timer_five_six;
    end

    // ************************************************************
    // enable registers
    // ************************************************************
    logic [vic_pkg::REQ_WIDTH-1:0] enable_reg;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            enable_reg <= {vic_pkg::ENABLE_RESET, vic_pkg::ENABLE_RESET};
        end
        else if (reg_we_i && reg_addr_i == vic_pkg::ADDR_ENABLE_ONE)
        begin
            enable_reg[7:0] <= reg_wdata_i & vic_pkg::LIVE_BITS;
        end
        else if (reg_we_i && reg_addr_i == vic_pkg::ADDR_ENABLE_TWO)
        begin
            enable_reg[15:8] <= reg_wdata_i & vic_pkg::LIVE_BITS;
        end
    end

    // ************************************************************
    // acceptance decision
    // ************************************************************
    vic_pkg::seq_state_t state_reg;
    logic [vic_pkg::REQ_WIDTH-1:0] request_reg;
    logic [vic_pkg::REQ_WIDTH-1:0] ready_vec;
    logic [vic_pkg::RANK_BITS-1:0] win_rank;
    logic i_flag_reg;
    logic break_pend_reg;
    logic take_maskable;
    logic take_break;

    assign ready_vec = request_reg & enable_reg;
    assign win_rank = pick_rank(ready_vec);
    assign take_maskable = boundary_i && state_reg == vic_pkg::ST_IDLE &&
        !i_flag_reg && (|ready_vec);
    // break trap is the lowest level and ignores the disable flag
    assign take_break = boundary_i && state_reg == vic_pkg::ST_IDLE &&
        break_pend_reg && !take_maskable;

    // ************************************************************
    // request registers
    // ************************************************************
    logic [vic_pkg::REQ_WIDTH-1:0] sw_clear;
    logic [vic_pkg::REQ_WIDTH-1:0] accept_clear;

    always_comb
    begin
        sw_clear = '0;
        if (reg_we_i && reg_addr_i == vic_pkg::ADDR_REQUEST_ONE)
        begin
            sw_clear[7:0] = ~reg_wdata_i;
        end
        if (reg_we_i && reg_addr_i == vic_pkg::ADDR_REQUEST_TWO)
        begin
            sw_clear[15:8] = ~reg_wdata_i;
        end
        accept_clear = take_maskable ? rank_mask(win_rank) : '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            request_reg <= {vic_pkg::REQUEST_RESET, vic_pkg::REQUEST_RESET};
        end
        else
        begin
            // a new event beats a clear in the same cycle
            request_reg <= ((request_reg & ~sw_clear & ~accept_clear) | event_vec) &
                {vic_pkg::LIVE_BITS, vic_pkg::LIVE_BITS};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            break_pend_reg <= 1'b0;
        end
        else if (break_software_trap_i)
        begin
            break_pend_reg <= 1'b1;
        end
        else if (take_break)
        begin
            break_pend_reg <= 1'b0;
        end
    end

    // ************************************************************
    // interrupt disable flag
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            i_flag_reg <= 1'b1;
        end
        else if (take_maskable || take_break || i_flag_set_i)
        begin
            i_flag_reg <= 1'b1;
        end
        else if (i_flag_clear_i && state_reg == vic_pkg::ST_IDLE)
        begin
            i_flag_reg <= 1'b0;
        end
    end

    // ************************************************************
    // register read port
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (reg_re_i)
        begin
            case (reg_addr_i)
                vic_pkg::ADDR_REQUEST_ONE: reg_rdata_o <= request_reg[7:0];
                vic_pkg::ADDR_REQUEST_TWO: reg_rdata_o <= request_reg[15:8];
                vic_pkg::ADDR_ENABLE_ONE: reg_rdata_o <= enable_reg[7:0];
                vic_pkg::ADDR_ENABLE_TWO: reg_rdata_o <= enable_reg[15:8];
                // unassigned polarity bits read zero
                vic_pkg::ADDR_POLARITY: reg_rdata_o <= polarity_reg & 8'hD8;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ************************************************************
    // stacking and vector sequence
    // ************************************************************
    logic [15:0] vec_reg;
    logic [15:0] pc_cap_reg;
    logic [7:0] ps_cap_reg;
    logic [7:0] sp_reg;
    logic [7:0] pc_low_reg;
    logic [7:0] pc_high_reg;
    logic pc_load_reg;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            // reset is the top level and needs no stacking
            state_reg <= vic_pkg::ST_VEC_LO;
            vec_reg <= vic_pkg::VEC_RESET;
            mem_o <= '{addr: vic_pkg::VEC_RESET, wdata: 8'h00, we: 1'b0, re: 1'b1};
            pc_cap_reg <= 16'h0000;
            ps_cap_reg <= 8'h00;
            sp_reg <= 8'h00;
            pc_low_reg <= 8'h00;
            pc_high_reg <= 8'h00;
            pc_load_reg <= 1'b0;
        end
        else
        begin
            pc_load_reg <= 1'b0;
            case (state_reg)
                vic_pkg::ST_IDLE:
                begin
                    if (take_maskable || take_break)
                    begin
                        // each maskable level has its own pair, two bytes apart
                        vec_reg <= take_maskable ?
                            vic_pkg::VEC_TOP_MASKABLE - {11'h000, win_rank, 1'b0} :
                            vic_pkg::VEC_BREAK;
                        pc_cap_reg <= pc_i;
                        ps_cap_reg <= status_i;
                        ps_cap_reg[vic_pkg::PS_B_BIT] <= take_break;
                        ps_cap_reg[vic_pkg::PS_I_BIT] <= i_flag_reg;
                        sp_reg <= sp_i;
                        mem_o <= '{addr: {stack_page_i, sp_i}, wdata: pc_i[15:8],
                            we: 1'b1, re: 1'b0};
                        state_reg <= vic_pkg::ST_PUSH_HI;
                    end
                end
                vic_pkg::ST_PUSH_HI:
                begin
                    mem_o <= '{addr: {stack_page_i, sp_reg - 8'h01},
                        wdata: pc_cap_reg[7:0], we: 1'b1, re: 1'b0};
                    state_reg <= vic_pkg::ST_PUSH_LO;
                end
                vic_pkg::ST_PUSH_LO:
                begin
                    mem_o <= '{addr: {stack_page_i, sp_reg - 8'h02},
                        wdata: ps_cap_reg, we: 1'b1, re: 1'b0};
                    state_reg <= vic_pkg::ST_PUSH_PS;
                end
                vic_pkg::ST_PUSH_PS:
                begin
                    sp_reg <= sp_reg - 8'h03;
                    mem_o <= '{addr: vec_reg, wdata: 8'h00, we: 1'b0, re: 1'b1};
                    state_reg <= vic_pkg::ST_VEC_LO;
                end
                vic_pkg::ST_VEC_LO:
                begin
                    mem_o <= '{addr: vec_reg + 16'h0001, wdata: 8'h00,
                        we: 1'b0, re: 1'b1};
                    state_reg <= vic_pkg::ST_VEC_HI;
                end
                vic_pkg::ST_VEC_HI:
                begin
                    pc_low_reg <= mem_rdata_i;
                    mem_o <= '{addr: 16'h0000, wdata: 8'h00, we: 1'b0, re: 1'b0};
                    state_reg <= vic_pkg::ST_LOAD;
                end
                vic_pkg::ST_LOAD:
                begin
                    pc_high_reg <= mem_rdata_i;
                    pc_load_reg <= 1'b1;
                    state_reg <= vic_pkg::ST_IDLE;
                end
                default:
                begin
                    mem_o <= '{addr: 16'h0000, wdata: 8'h00, we: 1'b0, re: 1'b0};
                    state_reg <= vic_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // outputs to the core
    // ************************************************************
    assign busy_o = state_reg != vic_pkg::ST_IDLE;
    assign i_flag_o = i_flag_reg;
    assign pc_load_o = pc_load_reg;
    assign prog_counter_high_o = pc_high_reg;
    assign prog_counter_low_o = pc_low_reg;
    assign sp_o = sp_reg;

    // status handed back with the disable flag forced
    always_comb
    begin
        processor_status_word_o = ps_cap_reg;
        processor_status_word_o[vic_pkg::PS_I_BIT] = i_flag_reg;
    end

endmodule

`default_nettype wire

// ### vic_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// answers a read one cycle later; otherwise shows inverted data, never a stale value
module vic_mem_model (
    input wire logic clk_i,
    input wire vic_pkg::mem_req_t mem_i,
    output var logic [7:0] rdata_o
);
    initial rdata_o = 8'h00;
    always @(posedge clk_i)
        rdata_o <= mem_i.re ? (mem_i.addr[7:0] ^ 8'h3C) : ~rdata_o;
endmodule
`default_nettype wire

// ### vic_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vic_asserts (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] sp_i,
    input wire logic [7:0] stack_page_i,
    input wire vic_pkg::mem_req_t mem_o,
    input wire logic i_flag_o,
    input wire logic pc_load_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_rdata_idle;
        !$past(reg_re_i) |-> reg_rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_push;
        $rose(mem_o.we) |-> mem_o.addr == {stack_page_i, sp_i} ##1 mem_o.we
            && mem_o.addr == {stack_page_i, sp_i - 8'h01} ##1 mem_o.we ##1 mem_o.re;
    endproperty
    a_push: assert property (p_push) else $error("stacking out of order");
    property p_flag;
        $rose(mem_o.we) |-> i_flag_o;
    endproperty
    a_flag: assert property (p_flag) else $error("disable flag not set");
    property p_mask;
        $rose(mem_o.we) |-> ##2 mem_o.wdata[vic_pkg::PS_B_BIT] || !mem_o.wdata[vic_pkg::PS_I_BIT];
    endproperty
    a_mask: assert property (p_mask) else $error("maskable taken while disabled");
    property p_vec;
        mem_o.re && $past(mem_o.re) && !$past(srst_i) |-> mem_o.addr == $past(mem_o.addr) + 16'h0001;
    endproperty
    a_vec: assert property (p_vec) else $error("vector pair not adjacent");
    property p_load;
        mem_o.re && $past(mem_o.re) |-> ##[1:3] pc_load_o;
    endproperty
    a_load: assert property (p_load) else $error("no load after vector fetch");
    property p_reset;
        $fell(srst_i) |-> i_flag_o && mem_o.re && mem_o.addr == vic_pkg::VEC_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("reset fetch wrong");
    property p_req_clear;
        reg_we_i && reg_addr_i == vic_pkg::ADDR_REQUEST_ONE && reg_wdata_i == 8'hFF ##2
            reg_re_i && reg_addr_i == vic_pkg::ADDR_REQUEST_ONE |=> reg_rdata_o == 8'h00;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request set by write");
endmodule
bind vectored_interrupt_control vic_asserts vic_asserts_i (.clk_i, .srst_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .sp_i, .stack_page_i, .mem_o,
    .i_flag_o, .pc_load_o);
`default_nettype wire

// ### tb_vectored_interrupt_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_control;
    localparam logic [15:0] RQ1 = vic_pkg::ADDR_REQUEST_ONE;
    localparam logic [15:0] RQ2 = vic_pkg::ADDR_REQUEST_TWO;
    localparam logic [15:0] EN1 = vic_pkg::ADDR_ENABLE_ONE;
    localparam logic [15:0] EN2 = vic_pkg::ADDR_ENABLE_TWO;
    localparam logic [15:0] POL = vic_pkg::ADDR_POLARITY;
    logic clk_i, srst_i, reg_we_i, reg_re_i, break_software_trap, bnd, fclr, fset, vs, busy_o, i_flag_o, pc_load_o;
    logic [15:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, mem_rdata_i, prog_counter_high, prog_counter_low, sp, psw;
    logic [2:0] pins;
    vic_pkg::periph_event_t evt;
    vic_pkg::mem_req_t mem_o;
    int failures = 0;
    int checks = 0;
    vectored_interrupt_control vectored_interrupt_control_i (.clk_i, .srst_i, .reg_addr_i,
        .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .ext_irq_pin_one_i(pins[0]),
        .ext_irq_pin_two_i(pins[1]), .ext_irq_pin_three_i(pins[2]), .vsync_i(vs),
        .periph_evt_i(evt), .break_software_trap_i(break_software_trap), .boundary_i(bnd),
        .i_flag_clear_i(fclr), .i_flag_set_i(fset), .pc_i(16'h1234), .status_i(8'h00),
        .sp_i(8'hFF), .stack_page_i(8'h01), .mem_o, .mem_rdata_i, .busy_o, .i_flag_o,
        .pc_load_o, .prog_counter_high_o(prog_counter_high), .prog_counter_low_o(prog_counter_low),
        .processor_status_word_o(psw), .sp_o(sp));
    vic_mem_model vic_mem_model_i (.clk_i, .mem_i(mem_o), .rdata_o(mem_rdata_i));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // ********
    // shared tasks
    // ********
    task report_and_stop;
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {reg_addr_i, reg_wdata_i, reg_we_i, reg_re_i} <= {a, d, 2'b10};
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i);
        {reg_addr_i, reg_re_i} <= {a, 1'b1};
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(negedge clk_i);
        chk({8'h00, reg_rdata_o}, {8'h00, e});
    endtask
    task pulse(input vic_pkg::periph_event_t e, input logic b, input logic s);
        @(posedge clk_i);
        {evt, break_software_trap, fset} <= {e, b, s};
        @(posedge clk_i);
        {evt, break_software_trap, fset} <= '0;
    endtask
    // memory model returns address low byte xor 3C
    function automatic logic [15:0] vpc(input logic [15:0] v);
        return {(v[7:0] + 8'h01) ^ 8'h3C, v[7:0] ^ 8'h3C};
    endfunction
    // go low: no acceptance may happen within the window
    task take(input logic [15:0] v, input logic clr, input logic go);
        logic seen;
        @(posedge clk_i);
        {fclr, bnd} <= {clr, 1'b1};
        @(posedge clk_i);
        fclr <= 1'b0;
        seen = 1'b0;
        for (int n = 0; n < 12 && !seen; n++)
        begin
            @(negedge clk_i);
            seen = (pc_load_o === 1'b1);
        end
        chk(go ? {prog_counter_high, prog_counter_low} : {14'h0000, busy_o, seen}, go ? vpc(v) : 16'h0000);
        @(posedge clk_i);
        bnd <= 1'b0;
    endtask
    // ********
    // scenarios
    // ********
    task t_regs;
        rd(POL, 8'h00);
        wr(POL, 8'hFF);
        rd(POL, 8'hD8);
        wr(POL, 8'h00);
        wr(EN2, 8'hFF);
        rd(EN2, 8'h7F);
        wr(EN2, 8'h00);
        wr(RQ1, 8'hFF);
        rd(RQ1, 8'h00);
        rd(16'h0100, 8'h00);
    endtask
    task t_prio;
        wr(EN1, 8'h11);
        pulse('{timer_one: 1'b1, screen_overlay_done_irq: 1'b1, default: 1'b0}, 1'b0, 1'b0);
        rd(RQ1, 8'h11);
        take(16'hFFFC, 1'b1, 1'b1);
        take(16'hFFEA, 1'b1, 1'b1);
        rd(RQ1, 8'h00);
        pulse('0, 1'b1, 1'b0);
        take(16'hFFDE, 1'b0, 1'b1);
        chk({sp, psw}, {8'hFC, 8'h14});
    endtask
    task t_mask;
        wr(EN1, 8'h02);
        pulse('{timer_two: 1'b1, timer_three: 1'b1, default: 1'b0}, 1'b0, 1'b1);
        take(16'h0000, 1'b0, 1'b0);
        take(16'hFFEC, 1'b1, 1'b1);
        take(16'h0000, 1'b1, 1'b0);
        wr(EN1, 8'h04);
        take(16'hFFEE, 1'b0, 1'b1);
    endtask
    task t_pins;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_i);
            pins[k] <= 1'b1;
            repeat (6) @(posedge clk_i);
            rd(RQ2, 8'h01 << k);
            wr(RQ2, 8'h00);
            wr(POL, 8'h08 << k);
            pins[k] <= 1'b0;
            repeat (6) @(posedge clk_i);
            rd(RQ2, 8'h01 << k);
            wr(RQ2, 8'h00);
        end
        wr(POL, 8'h40);
        {vs, pins[2]} <= 2'b11;
        repeat (6) @(posedge clk_i);
        rd(RQ1, 8'h20);
        @(posedge clk_i);
        pins[2] <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(RQ1, 8'h60);
        wr(RQ1, 8'h00);
        wr(POL, 8'h80);
        pins[2] <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(RQ1, 8'h00);
        pulse('{adc_done: 1'b1, default: 1'b0}, 1'b0, 1'b0);
        rd(RQ1, 8'h40);
    endtask
    initial
    begin
        {srst_i, reg_we_i, reg_re_i, break_software_trap, bnd, fclr, fset, vs, pins} = 11'h400;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 8'h00;
        evt = '0;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        take(vic_pkg::VEC_RESET, 1'b0, 1'b1);
        chk({15'h0000, i_flag_o}, 16'h0001);
        t_regs;
        t_prio;
        t_mask;
        t_pins;
        report_and_stop;
    end
    initial
    begin
        #20000;
        failures++;
        report_and_stop;
    end
endmodule
`default_nettype wire
